// >>> rstc_top.sv
/*
  chip mode control: reset, global enable, setup mode, tri-state and
  in-circuit test modes, strap capture, drive select, write protect,
  extension register access and the synthesizer power-down output.
  assumes an 8-bit host i/o port with one-cycle read and write strobes,
  and a memory clock pin that is sampled on CLK_I.
*/
`timescale 1ns/1ps
`include "rstc_params.svh"

module rstc_top
  import rstc_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // chip pins
  input wire logic RESET_PIN_I,
  input wire logic MEMORY_CLOCK_INPUT_I,
  input wire logic MEM_BANK_A_DATA0_I,
  input wire logic MEM_BANK_B_DATA0_I,
  input wire logic MEM_BANK_A_DATA1_I,
  input wire logic MEM_BANK_B_DATA1_I,
  input wire logic [7:0] STRAP_I,
  input wire logic SETUP_SEL_N_I,
  input wire logic STANDBY_IN_N_I,
  input wire logic PANEL_LOGIC_POWER_EN_N_I,
  input wire logic FOUR_VRAM_I,
  input wire logic VIDEO_ACTIVE_I,
  input wire logic [15:0] ICT_PINS_I,
  // host i/o port
  input wire logic [15:0] IO_ADDR_I,
  input wire logic [7:0] IO_WDATA_I,
  input wire logic IO_WR_I,
  input wire logic IO_RD_I,
  input wire logic [3:0] STD_WR_GROUP_I,
  // outputs
  output logic [7:0] IO_RDATA_O,
  output logic IO_ACK_O,
  output logic [3:0] STD_WR_ALLOW_O,
  output logic CHIP_ENABLED_O,
  output logic SETUP_MODE_O,
  output logic COMPAT_MODE_O,
  output logic CRT_SELECT_O,
  output logic VIDEO_OUT_EN_O,
  output logic STANDBY_O,
  output logic TRISTATE_O,
  output logic INCIRCUIT_TEST_MODE_O,
  output logic VSYNC_O,
  output logic VSYNC_OE_O,
  output logic SYNTH_POWERDOWN_OUT_N_O,
  output logic SYNTH_POWERDOWN_OE_O,
  output logic [2:0] DRIVE_DOUBLE_O,
  output logic [1:0] BUS_TYPE_O
);

  // ==========================================
  // state
  logic [7:0] xr_index_reg, output_drive_reg, write_protect_reg, port_disable_ctl, strap_reg;
  logic global_en_reg, setup_reg, setup_video_reg, reset_last_reg;
  rstc_test_t test_reg;
  rstc_bus_t bus_type;
  logic mclk_rise, chain_high, setup_active;
  logic io_hit_index, io_hit_data, io_hit_setup, io_hit_gen;

  rstc_edge rstc_edge_inst
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sig_i(MEMORY_CLOCK_INPUT_I), .rise_o(mclk_rise));

  rstc_chain #(.W(16)) rstc_chain_inst
  (.pins_i(ICT_PINS_I), .all_high_o(chain_high));

  // ==========================================
  // address decode
  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] p);
    addr_is = (a == p);
  endfunction

  assign bus_type = rstc_bus_t'({strap_reg[1], strap_reg[0]});
  assign setup_active = setup_reg | ((bus_type == RSTC_BUS_ADDIN) & ~SETUP_SEL_N_I);
  assign io_hit_index = addr_is(IO_ADDR_I, `RSTC_IO_XR_INDEX) & ~setup_active;
  assign io_hit_data = addr_is(IO_ADDR_I, `RSTC_IO_XR_DATA) & ~setup_active;
  assign io_hit_setup = addr_is(IO_ADDR_I, `RSTC_IO_SETUP_PORT) & (bus_type == RSTC_BUS_ISA)
    & ~port_disable_ctl[`RSTC_PDIS_SETUP_BIT];
  // in setup mode the global enable sits at 102h, elsewhere at 3C3h on direct buses
  assign io_hit_gen = setup_active ? addr_is(IO_ADDR_I, `RSTC_IO_GLOBAL_EN_SETUP)
    : (addr_is(IO_ADDR_I, `RSTC_IO_GLOBAL_EN_DIRECT) & (bus_type inside {RSTC_BUS_PI, RSTC_BUS_LOCAL})
    & ~port_disable_ctl[`RSTC_PDIS_GEN_BIT]);

  // ==========================================
  // strap capture on reset fall
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      reset_last_reg <= 1'b0;
    else
      reset_last_reg <= RESET_PIN_I;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      strap_reg <= 8'hff;
    else if (reset_last_reg && !RESET_PIN_I)
      strap_reg <= STRAP_I;
  end

  // ==========================================
  // extension registers; reset pin clears them, index access gated off while setup is active
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      xr_index_reg <= 8'h00;
      output_drive_reg <= `RSTC_DRV_RESET;
      write_protect_reg <= `RSTC_WP_RESET;
      port_disable_ctl <= `RSTC_PDIS_RESET;
    end
    else if (RESET_PIN_I)
    begin
      xr_index_reg <= 8'h00;
      output_drive_reg <= `RSTC_DRV_RESET;
      write_protect_reg <= `RSTC_WP_RESET;
      port_disable_ctl <= `RSTC_PDIS_RESET;
    end
    else if (IO_WR_I && io_hit_index)
      xr_index_reg <= IO_WDATA_I;
    else if (IO_WR_I && io_hit_data)
    begin
      unique case (xr_index_reg)
        `RSTC_XR_OUTPUT_DRIVE: output_drive_reg <= IO_WDATA_I;
        `RSTC_XR_WRITE_PROTECT: write_protect_reg <= IO_WDATA_I;
        `RSTC_XR_PORT_DISABLE: port_disable_ctl <= IO_WDATA_I;
        default: ;
      endcase
    end
  end

  // ==========================================
  // global enable and setup mode
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      global_en_reg <= 1'b0;
    else if (RESET_PIN_I)
      global_en_reg <= 1'b0;
    else if (IO_WR_I && io_hit_gen)
      global_en_reg <= IO_WDATA_I[`RSTC_GEN_BIT];
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      setup_reg <= 1'b0;
    else if (RESET_PIN_I)
      setup_reg <= 1'b0;
    else if (IO_WR_I && io_hit_setup)
      setup_reg <= IO_WDATA_I[`RSTC_SETUP_BIT];
  end

  // video state frozen while setup is active
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      setup_video_reg <= 1'b0;
    else if (!setup_active)
      setup_video_reg <= VIDEO_ACTIVE_I;
  end

  // ==========================================
  // tri-state and in-circuit test modes
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      test_reg <= RSTC_TM_NORMAL;
    else
    begin
      unique case (test_reg)
        RSTC_TM_NORMAL:
          if (mclk_rise && RESET_PIN_I && !MEM_BANK_A_DATA0_I && !MEM_BANK_B_DATA0_I)
            test_reg <= RSTC_TM_TRISTATE;
          else if (mclk_rise && RESET_PIN_I && !MEM_BANK_A_DATA1_I && !MEM_BANK_B_DATA1_I)
            test_reg <= RSTC_TM_ICT;
        RSTC_TM_TRISTATE:
          if (MEM_BANK_A_DATA0_I || MEM_BANK_B_DATA0_I || !RESET_PIN_I)
            test_reg <= RSTC_TM_NORMAL;
        RSTC_TM_ICT:
          // exit only on a clock rise, so the tester must move the clock pin last
          if (mclk_rise && (MEM_BANK_A_DATA1_I || MEM_BANK_B_DATA1_I || !RESET_PIN_I))
            test_reg <= RSTC_TM_NORMAL;
      endcase
    end
  end

  // ==========================================
  // registered outputs
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      IO_RDATA_O <= 8'h00;
      IO_ACK_O <= 1'b0;
    end
    else
    begin
      IO_ACK_O <= (IO_RD_I || IO_WR_I) && (io_hit_index || io_hit_data || io_hit_gen || io_hit_setup);
      IO_RDATA_O <= 8'h00;
      if (IO_RD_I && io_hit_index)
        IO_RDATA_O <= xr_index_reg;
      else if (IO_RD_I && io_hit_gen)
        IO_RDATA_O <= {7'h00, global_en_reg};
      else if (IO_RD_I && io_hit_setup)
        IO_RDATA_O <= {3'h0, setup_reg, 4'h0};
      else if (IO_RD_I && io_hit_data)
      begin
        unique case (xr_index_reg)
          `RSTC_XR_OUTPUT_DRIVE: IO_RDATA_O <= output_drive_reg;
          `RSTC_XR_WRITE_PROTECT: IO_RDATA_O <= write_protect_reg;
          `RSTC_XR_PORT_DISABLE: IO_RDATA_O <= port_disable_ctl;
          `RSTC_XR_STRAPS: IO_RDATA_O <= strap_reg;
          default: IO_RDATA_O <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      STD_WR_ALLOW_O <= 4'h0;
      CHIP_ENABLED_O <= 1'b0;
      SETUP_MODE_O <= 1'b0;
      COMPAT_MODE_O <= 1'b1;
      CRT_SELECT_O <= 1'b1;
      VIDEO_OUT_EN_O <= 1'b0;
      STANDBY_O <= 1'b0;
      DRIVE_DOUBLE_O <= 3'h0;
      BUS_TYPE_O <= 2'h3;
    end
    else
    begin
      STD_WR_ALLOW_O <= STD_WR_GROUP_I & ~write_protect_reg[3:0];
      CHIP_ENABLED_O <= global_en_reg & ~RESET_PIN_I;
      SETUP_MODE_O <= setup_active;
      COMPAT_MODE_O <= RESET_PIN_I;
      CRT_SELECT_O <= RESET_PIN_I;
      VIDEO_OUT_EN_O <= setup_active ? setup_video_reg : VIDEO_ACTIVE_I;
      STANDBY_O <= ~STANDBY_IN_N_I;
      DRIVE_DOUBLE_O <= {output_drive_reg[`RSTC_DRV_MEM_BIT], output_drive_reg[`RSTC_DRV_BUS_BIT],
        output_drive_reg[`RSTC_DRV_PANEL_BIT]};
      BUS_TYPE_O <= 2'(bus_type);
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      TRISTATE_O <= 1'b0;
      INCIRCUIT_TEST_MODE_O <= 1'b0;
      VSYNC_O <= 1'b0;
      VSYNC_OE_O <= 1'b0;
      SYNTH_POWERDOWN_OUT_N_O <= 1'b1;
      SYNTH_POWERDOWN_OE_O <= 1'b0;
    end
    else
    begin
      TRISTATE_O <= (test_reg == RSTC_TM_TRISTATE) || (test_reg == RSTC_TM_ICT);
      INCIRCUIT_TEST_MODE_O <= (test_reg == RSTC_TM_ICT);
      VSYNC_O <= chain_high;
      VSYNC_OE_O <= (test_reg != RSTC_TM_TRISTATE);
      SYNTH_POWERDOWN_OUT_N_O <= ~(~STANDBY_IN_N_I & PANEL_LOGIC_POWER_EN_N_I);
      SYNTH_POWERDOWN_OE_O <= ~FOUR_VRAM_I && (test_reg == RSTC_TM_NORMAL);
    end
  end

  // ==========================================
  // checks
  AST_SYNTH_PD: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    1'b1 |=> SYNTH_POWERDOWN_OUT_N_O == !($past(!STANDBY_IN_N_I) && $past(PANEL_LOGIC_POWER_EN_N_I)))
    else $error("synth power-down mismatch");
  AST_FOUR_VRAM: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    FOUR_VRAM_I |=> !SYNTH_POWERDOWN_OE_O) else $error("power-down driven in four vram mode");
  AST_DRIVE_BITS: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    ##1 DRIVE_DOUBLE_O == {$past(output_drive_reg[4]), $past(output_drive_reg[3]), $past(output_drive_reg[2])})
    else $error("drive select mismatch");
  AST_PROTECT: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    write_protect_reg[0] |=> !STD_WR_ALLOW_O[0]) else $error("protected group allowed");
  AST_RESET_DISABLE: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    RESET_PIN_I |=> !global_en_reg && !CHIP_ENABLED_O && CRT_SELECT_O) else $error("enabled in reset");
  AST_SETUP_FREEZE: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    setup_active && $past(setup_active) |=> VIDEO_OUT_EN_O == $past(setup_video_reg))
    else $error("video state moved in setup");
  AST_TRI_ENTER: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    test_reg == RSTC_TM_NORMAL && mclk_rise && RESET_PIN_I && !MEM_BANK_A_DATA0_I && !MEM_BANK_B_DATA0_I
    |=> test_reg == RSTC_TM_TRISTATE ##1 TRISTATE_O) else $error("tri-state not entered");
  AST_TRI_EXIT: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    test_reg == RSTC_TM_TRISTATE && !RESET_PIN_I |=> test_reg == RSTC_TM_NORMAL) else $error("tri-state held");
  AST_ICT_HOLD: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    test_reg == RSTC_TM_ICT && !mclk_rise |=> test_reg == RSTC_TM_ICT) else $error("test mode left without clock");
  AST_ICT_VSYNC: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    test_reg == RSTC_TM_ICT |=> VSYNC_OE_O && VSYNC_O == $past(&ICT_PINS_I)) else $error("chain output wrong");
  AST_STRAP: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    $fell(RESET_PIN_I) |=> strap_reg == $past(STRAP_I)) else $error("strap not captured");

  COV_TRI: cover property (@(posedge CLK_I) disable iff (!RSTN_I) test_reg == RSTC_TM_TRISTATE);
  COV_ICT: cover property (@(posedge CLK_I) disable iff (!RSTN_I) test_reg == RSTC_TM_ICT);
  COV_SETUP: cover property (@(posedge CLK_I) disable iff (!RSTN_I) $rose(setup_active));
  COV_ENABLE: cover property (@(posedge CLK_I) disable iff (!RSTN_I) $rose(CHIP_ENABLED_O));
endmodule

// >>> rstc_params.svh
/*
  constants for the reset, setup and test mode control block.
  assumes inclusion by bare name; holds definitions only.
*/
`ifndef RSTC_PARAMS_SVH
`define RSTC_PARAMS_SVH

// ==========================================
// register indices and host ports
`define RSTC_XR_OUTPUT_DRIVE 8'h6c
`define RSTC_XR_WRITE_PROTECT 8'h15
`define RSTC_XR_PORT_DISABLE 8'h70
`define RSTC_XR_STRAPS 8'h01
`define RSTC_IO_XR_INDEX 16'h03d6
`define RSTC_IO_XR_DATA 16'h03d7
`define RSTC_IO_GLOBAL_EN_SETUP 16'h0102
`define RSTC_IO_GLOBAL_EN_DIRECT 16'h03c3
`define RSTC_IO_SETUP_PORT 16'h46e8

// ==========================================
// field positions
`define RSTC_DRV_PANEL_BIT 2
`define RSTC_DRV_BUS_BIT 3
`define RSTC_DRV_MEM_BIT 4
`define RSTC_SETUP_BIT 4
`define RSTC_GEN_BIT 0
`define RSTC_PDIS_SETUP_BIT 0
`define RSTC_PDIS_GEN_BIT 1

// ==========================================
// reset values
`define RSTC_DRV_RESET 8'h00
`define RSTC_WP_RESET 8'h00
`define RSTC_PDIS_RESET 8'h00

// ==========================================
// timing
`define RSTC_RESET_MIN_CYCLES 64

`endif

// >>> rstc_pkg.sv
/*
  types for the reset, setup and test mode control block.
  assumes nothing beyond the params header.
*/
package rstc_pkg;

  typedef enum logic [1:0]
  {
    RSTC_BUS_PI,
    RSTC_BUS_ADDIN,
    RSTC_BUS_LOCAL,
    RSTC_BUS_ISA
  } rstc_bus_t;

  typedef enum
  {
    RSTC_TM_NORMAL,
    RSTC_TM_TRISTATE,
    RSTC_TM_ICT
  } rstc_test_t;

endpackage

// >>> rstc_edge.sv
/*
  rising edge detector for a synchronous input.
  assumes the input is already synchronous to clk_i.
*/
`timescale 1ns/1ps
module rstc_edge
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sig_i,
  output logic rise_o
);
  logic last_reg;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      last_reg <= 1'b0;
    else
      last_reg <= sig_i;
  end

  assign rise_o = sig_i & ~last_reg;
endmodule

// >>> rstc_chain.sv
/*
  and-chain of the pins under in-circuit test.
  assumes the pin vector is sampled synchronously.
*/
`timescale 1ns/1ps
module rstc_chain #(parameter int W = 16)
(
  input wire logic [W-1:0] pins_i,
  output logic all_high_o
);
  logic [W:0] acc;

  assign acc[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_and
      assign acc[g+1] = acc[g] & pins_i[g];
    end
  endgenerate
  assign all_high_o = acc[W];
endmodule

// >>> rstc_board.sv
/*
  board-side partner: reset pin source and memory clock pin of a tester.
  assumes the bench asks for reset and clock pulses on CLK_I edges.
*/
`timescale 1ns/1ps
module rstc_board
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // requests from the bench
  input wire logic hold_i,
  input wire logic mclk_req_i,
  // board pins
  output logic reset_pin_o,
  output logic mclk_o
);
  logic [6:0] hold_cnt_reg;
  logic [2:0] mclk_cnt_reg;

  // ==========================================
  // reset pin: never shorter than the minimum, even if the bench lets go early
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hold_cnt_reg <= 7'h00;
      reset_pin_o <= 1'b1;
    end
    else if (reset_pin_o)
    begin
      if (hold_cnt_reg < 7'h40)
        hold_cnt_reg <= hold_cnt_reg + 7'h01;
      else if (!hold_i)
        reset_pin_o <= 1'b0;
    end
    else if (hold_i)
    begin
      hold_cnt_reg <= 7'h00;
      reset_pin_o <= 1'b1;
    end
  end

  // ==========================================
  // memory clock: one slow pulse per request, still between requests
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      mclk_cnt_reg <= 3'h0;
    else if (mclk_cnt_reg != 3'h0 || mclk_req_i)
      mclk_cnt_reg <= mclk_cnt_reg + 3'h1;
  end

  assign mclk_o = mclk_cnt_reg[2];
endmodule

// >>> test_rstc_top.sv
/*
  self-checking bench for the chip mode control block.
  assumes the design header and package are compiled first.
*/
`timescale 1ns/1ps
`include "rstc_params.svh"
module test_rstc_top;
  import rstc_pkg::*;
  logic CLK_I = 1'b0, RSTN_I = 1'b0, hold = 1'b0, mclk_req = 1'b0, reset_pin, mclk;
  logic A0 = 1'b1, B0 = 1'b1, A1 = 1'b1, B1 = 1'b1, SETUP_SEL_N_I = 1'b1, STBY_N = 1'b1;
  logic PANEL = 1'b0, FOUR_VRAM_I = 1'b0, VIDEO_ACTIVE_I = 1'b1, IO_WR_I = 1'b0, IO_RD_I = 1'b0;
  logic [7:0] STRAP_I = 8'h03, IO_WDATA_I = 8'h00, IO_RDATA_O;
  logic [15:0] ICT_PINS_I = 16'hffff, IO_ADDR_I = 16'h0000;
  logic [3:0] STD_WR_GROUP_I = 4'h0, STD_WR_ALLOW_O;
  logic IO_ACK_O, CHIP_ENABLED_O, SETUP_MODE_O, COMPAT_MODE_O, CRT_SELECT_O, VIDEO_OUT_EN_O;
  logic STANDBY_O, TRISTATE_O, INCIRCUIT_TEST_MODE_O, VSYNC_O, VSYNC_OE_O, SYNTH_N, SYNTH_OE;
  logic [2:0] DRIVE_DOUBLE_O;
  logic [1:0] BUS_TYPE_O;
  int n_fail = 0, samples_checked = 0, cyc = 0;

  always #4 CLK_I = ~CLK_I;

  rstc_board rstc_board_inst (.clk_i(CLK_I), .rstn_i(RSTN_I), .hold_i(hold), .mclk_req_i(mclk_req),
    .reset_pin_o(reset_pin), .mclk_o(mclk));

  rstc_top rstc_top_inst (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .RESET_PIN_I(reset_pin),
    .MEMORY_CLOCK_INPUT_I(mclk), .MEM_BANK_A_DATA0_I(A0), .MEM_BANK_B_DATA0_I(B0),
    .MEM_BANK_A_DATA1_I(A1), .MEM_BANK_B_DATA1_I(B1), .STRAP_I(STRAP_I), .SETUP_SEL_N_I(SETUP_SEL_N_I),
    .STANDBY_IN_N_I(STBY_N), .PANEL_LOGIC_POWER_EN_N_I(PANEL), .FOUR_VRAM_I(FOUR_VRAM_I),
    .VIDEO_ACTIVE_I(VIDEO_ACTIVE_I), .ICT_PINS_I(ICT_PINS_I), .IO_ADDR_I(IO_ADDR_I),
    .IO_WDATA_I(IO_WDATA_I), .IO_WR_I(IO_WR_I), .IO_RD_I(IO_RD_I), .STD_WR_GROUP_I(STD_WR_GROUP_I),
    .IO_RDATA_O(IO_RDATA_O), .IO_ACK_O(IO_ACK_O), .STD_WR_ALLOW_O(STD_WR_ALLOW_O),
    .CHIP_ENABLED_O(CHIP_ENABLED_O), .SETUP_MODE_O(SETUP_MODE_O), .COMPAT_MODE_O(COMPAT_MODE_O),
    .CRT_SELECT_O(CRT_SELECT_O), .VIDEO_OUT_EN_O(VIDEO_OUT_EN_O), .STANDBY_O(STANDBY_O),
    .TRISTATE_O(TRISTATE_O), .INCIRCUIT_TEST_MODE_O(INCIRCUIT_TEST_MODE_O), .VSYNC_O(VSYNC_O),
    .VSYNC_OE_O(VSYNC_OE_O), .SYNTH_POWERDOWN_OUT_N_O(SYNTH_N), .SYNTH_POWERDOWN_OE_O(SYNTH_OE),
    .DRIVE_DOUBLE_O(DRIVE_DOUBLE_O), .BUS_TYPE_O(BUS_TYPE_O));

  // ==========================================
  // helpers
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // a hang must never look like a pass
  always @(posedge CLK_I)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_fail++;
      $display("Error at %0t: timeout", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask

  task automatic wait_rp(input logic v);
    for (int i = 0; i < 300 && reset_pin !== v; i++)
      @(posedge CLK_I);
    wait_cyc(3);
  endtask

  // one-cycle strobe; answer stands in the following cycle only
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic ack,
    input logic [7:0] rd);
    @(posedge CLK_I);
    IO_ADDR_I <= a;
    IO_WDATA_I <= d;
    IO_WR_I <= wr;
    IO_RD_I <= !wr;
    @(posedge CLK_I);
    IO_WR_I <= 1'b0;
    IO_RD_I <= 1'b0;
    #1;
    chk(8'(IO_ACK_O), 8'(ack), "ack");
    if (!wr)
      chk(IO_RDATA_O, rd, "read data");
  endtask

  task automatic xw(input logic [7:0] idx, input logic [7:0] d);
    io(1'b1, `RSTC_IO_XR_INDEX, idx, 1'b1, 8'h00);
    io(1'b1, `RSTC_IO_XR_DATA, d, 1'b1, 8'h00);
  endtask

  task automatic xr(input logic [7:0] idx, input logic [7:0] exp);
    io(1'b1, `RSTC_IO_XR_INDEX, idx, 1'b1, 8'h00);
    io(1'b0, `RSTC_IO_XR_DATA, 8'h00, 1'b1, exp);
  endtask

  task automatic pin_reset(input logic [7:0] s);
    @(posedge CLK_I);
    STRAP_I <= s;
    hold <= 1'b1;
    wait_rp(1'b1);
    chk(8'({COMPAT_MODE_O, CRT_SELECT_O, CHIP_ENABLED_O}), 8'h06, "reset modes");
    @(posedge CLK_I);
    hold <= 1'b0;
    wait_rp(1'b0);
    chk(8'(BUS_TYPE_O), 8'(s[1:0]), "bus type");
  endtask

  task automatic mclk_pulse();
    @(posedge CLK_I);
    mclk_req <= 1'b1;
    @(posedge CLK_I);
    mclk_req <= 1'b0;
    wait_cyc(12);
  endtask

  // ==========================================
  // sequence
  initial
  begin
    repeat (8) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    wait_rp(1'b1);
    chk(8'({COMPAT_MODE_O, CRT_SELECT_O, CHIP_ENABLED_O}), 8'h06, "reset modes");
    wait_rp(1'b0);
    chk(8'({COMPAT_MODE_O, CRT_SELECT_O, CHIP_ENABLED_O}), 8'h00, "disabled after reset");
    xr(`RSTC_XR_STRAPS, 8'h03);
    xr(`RSTC_XR_OUTPUT_DRIVE, `RSTC_DRV_RESET);
    xr(`RSTC_XR_WRITE_PROTECT, `RSTC_WP_RESET);
    xr(`RSTC_XR_PORT_DISABLE, `RSTC_PDIS_RESET);
    for (int b = 0; b < 3; b++)
    begin
      xw(`RSTC_XR_OUTPUT_DRIVE, 8'h04 << b);
      wait_cyc(1);
      chk(8'(DRIVE_DOUBLE_O), 8'h01 << b, "drive select");
      xr(`RSTC_XR_OUTPUT_DRIVE, 8'h04 << b);
    end
    xw(`RSTC_XR_WRITE_PROTECT, 8'h05);
    @(posedge CLK_I);
    STD_WR_GROUP_I <= 4'hf;
    @(posedge CLK_I);
    STD_WR_GROUP_I <= 4'h0;
    #1;
    chk(8'(STD_WR_ALLOW_O), 8'h0a, "group protect");
    io(1'b0, 16'h03d0, 8'h00, 1'b0, 8'h00);
    io(1'b1, `RSTC_IO_GLOBAL_EN_DIRECT, 8'h01, 1'b0, 8'h00);
    io(1'b1, `RSTC_IO_GLOBAL_EN_SETUP, 8'h01, 1'b0, 8'h00);
    xw(`RSTC_XR_PORT_DISABLE, 8'h01);
    io(1'b1, `RSTC_IO_SETUP_PORT, 8'h10, 1'b0, 8'h00);
    wait_cyc(1);
    chk(8'({SETUP_MODE_O, CHIP_ENABLED_O}), 8'h00, "port disabled");
    xw(`RSTC_XR_PORT_DISABLE, 8'h00);
    io(1'b1, `RSTC_IO_SETUP_PORT, 8'h10, 1'b1, 8'h00);
    wait_cyc(1);
    chk(8'(SETUP_MODE_O), 8'h01, "setup entered");
    @(posedge CLK_I);
    VIDEO_ACTIVE_I <= 1'b0;
    wait_cyc(3);
    chk(8'(VIDEO_OUT_EN_O), 8'h01, "video held in setup");
    io(1'b0, `RSTC_IO_XR_DATA, 8'h00, 1'b0, 8'h00);
    io(1'b1, `RSTC_IO_GLOBAL_EN_SETUP, 8'h01, 1'b1, 8'h00);
    wait_cyc(1);
    chk(8'(CHIP_ENABLED_O), 8'h01, "enabled");
    @(posedge CLK_I);
    VIDEO_ACTIVE_I <= 1'b1;
    pin_reset(8'h01);
    @(posedge CLK_I);
    SETUP_SEL_N_I <= 1'b0;
    wait_cyc(3);
    chk(8'(SETUP_MODE_O), 8'h01, "setup by pin");
    io(1'b1, `RSTC_IO_GLOBAL_EN_SETUP, 8'h01, 1'b1, 8'h00);
    wait_cyc(1);
    chk(8'(CHIP_ENABLED_O), 8'h01, "enabled in pin setup");
    @(posedge CLK_I);
    SETUP_SEL_N_I <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      pin_reset(8'(k * 2));
      xw(`RSTC_XR_PORT_DISABLE, 8'h02);
      io(1'b1, `RSTC_IO_GLOBAL_EN_DIRECT, 8'h01, 1'b0, 8'h00);
      xw(`RSTC_XR_PORT_DISABLE, 8'h00);
      io(1'b1, `RSTC_IO_GLOBAL_EN_DIRECT, 8'h01, 1'b1, 8'h00);
      wait_cyc(1);
      chk(8'(CHIP_ENABLED_O), 8'h01, "direct enable");
    end
    for (int i = 0; i < 5; i++)
    begin
      @(posedge CLK_I);
      {FOUR_VRAM_I, STBY_N, PANEL} <= 3'(i < 4 ? i : 6);
      wait_cyc(3);
      chk(8'(SYNTH_N), 8'(i != 1), "synth power-down");
      chk(8'(STANDBY_O), 8'(i < 2), "standby");
      chk(8'(SYNTH_OE), 8'(i < 4), "synth pin available");
    end
    @(posedge CLK_I);
    FOUR_VRAM_I <= 1'b0;
    // tri-state left once by a data pin with reset still high, once by reset going low
    for (int k = 0; k < 2; k++)
    begin
      @(posedge CLK_I);
      hold <= 1'b1;
      {A0, B0} <= 2'b00;
      wait_rp(1'b1);
      mclk_pulse();
      chk(8'({TRISTATE_O, VSYNC_OE_O, SYNTH_OE}), 8'h04, "tri-state");
      @(posedge CLK_I);
      if (k == 0)
        B0 <= 1'b1;
      else
        hold <= 1'b0;
      if (k == 0)
        wait_cyc(3);
      else
        wait_rp(1'b0);
      chk(8'(TRISTATE_O), 8'h00, "tri-state exit");
      @(posedge CLK_I);
      {A0, B0} <= 2'b11;
    end
    @(posedge CLK_I);
    hold <= 1'b1;
    {A1, B1} <= 2'b00;
    wait_rp(1'b1);
    mclk_pulse();
    chk(8'({INCIRCUIT_TEST_MODE_O, TRISTATE_O, VSYNC_OE_O}), 8'h07, "test mode");
    chk(8'(VSYNC_O), 8'h01, "chain all high");
    for (int b = 0; b < 16; b++)
    begin
      @(posedge CLK_I);
      ICT_PINS_I <= ~(16'h0001 << b);
      wait_cyc(3);
      chk(8'(VSYNC_O), 8'h00, "chain one low");
    end
    @(posedge CLK_I);
    ICT_PINS_I <= 16'hffff;
    A1 <= 1'b1;
    wait_cyc(5);
    chk(8'({INCIRCUIT_TEST_MODE_O, VSYNC_OE_O}), 8'h03, "test mode held");
    mclk_pulse();
    chk(8'(INCIRCUIT_TEST_MODE_O), 8'h00, "test mode exit");
    @(posedge CLK_I);
    {B1, hold} <= 2'b10;
    wait_rp(1'b0);
    give_verdict();
  end
endmodule
